// File: coproc_bus_if.sv
/*
 * pin bundle between host and coprocessor port, with wire resolution.
 * assumes pull-ups on acks and data when nobody drives.
 */
`timescale 1ns/100ps
`default_nettype none
interface coproc_bus_if;
	// ==================================================
	// host driven pins
	logic [4:0] addr; // address lines
	logic size_sel; // width select, high for 16/32
	logic rw; // high reads
	logic cs_n; // chip select
	logic addr_strobe_n;
	logic data_strobe_n;
	logic [31:0] host_data;
	logic host_data_oe;
	// device driven pins
	logic [31:0] dev_data;
	logic [3:0] dev_data_oe; // one per byte lane
	logic xfer_ack_first_n;
	logic xfer_ack_second_n;
	logic ack_oe;
	// resolved wire levels
	logic [31:0] data_bus;
	logic ack_first_bus_n;
	logic ack_second_bus_n;
	// ==================================================
	// pull-up resolution, device lanes win over host
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (dev_data_oe[i/8]) data_bus[i] = dev_data[i];
			else if (host_data_oe) data_bus[i] = host_data[i];
			else data_bus[i] = 1'b1;
		end
		ack_first_bus_n = ack_oe ? xfer_ack_first_n : 1'b1;
		ack_second_bus_n = ack_oe ? xfer_ack_second_n : 1'b1;
	end
	modport device_mp (input addr, size_sel, rw, cs_n, addr_strobe_n,
		data_strobe_n, data_bus, output dev_data, dev_data_oe,
		xfer_ack_first_n, xfer_ack_second_n, ack_oe);
	modport host_mp (output addr, size_sel, rw, cs_n, addr_strobe_n,
		data_strobe_n, host_data, host_data_oe, input data_bus,
		ack_first_bus_n, ack_second_bus_n);
endinterface : coproc_bus_if
`default_nettype wire

// File: coproc_port_dev.sv
/*
 * coprocessor end of the port: decodes width, steers lanes, answers
 * with the acknowledge pair, gathers items into long words.
 * assumes a host that keeps strobes low until acknowledged.
 */
`timescale 1ns/100ps
`default_nettype none
module coproc_port_dev
	import coproc_port_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	coproc_bus_if.device_mp bus,
	output logic rx_valid, // gathered item for the user
	output logic [31:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid, // item to be read by the host
	input wire logic [31:0] tx_data,
	output logic tx_ready // one-cycle pulse, item fully read
);
	typedef enum logic [1:0] {IDLE, ACK, REL} dev_state_type;
	// ==================================================
	// pin synchronisers
	logic [2:0] strb_m_r; // first stage, read only by second
	logic [2:0] strb_s_r;
	logic [38:0] pin_m_r;
	logic [38:0] pin_s_r;
	logic sel; // chip selected and both strobes low
	logic [4:0] a_s;
	logic rw_s;
	logic size_s;
	logic [31:0] d_s;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strb_m_r <= 3'h7;
			strb_s_r <= 3'h7;
			pin_m_r <= 39'h0;
			pin_s_r <= 39'h0;
		end else begin
			strb_m_r <= {bus.cs_n, bus.addr_strobe_n, bus.data_strobe_n};
			strb_s_r <= strb_m_r;
			pin_m_r <= {bus.size_sel, bus.rw, bus.addr, bus.data_bus};
			pin_s_r <= pin_m_r;
		end
	end
	assign sel = (strb_s_r == 3'h0);
	assign {size_s, rw_s, a_s, d_s} = pin_s_r;
	// ==================================================
	// bus cycle sequencer
	dev_state_type state_r, state_nxt;
	logic [1:0] ack_r, ack_nxt; // {second, first}
	logic ack_oe_r, ack_oe_nxt;
	logic [31:0] dout_r, dout_nxt;
	logic [3:0] doe_r, doe_nxt;
	logic [2:0] cnt_r, cnt_nxt; // bytes of current item so far
	logic [31:0] asm_r, asm_nxt; // write gathering
	logic [31:0] rdw_r, rdw_nxt; // read word still to send
	logic tx_ready_r, tx_ready_nxt;
	logic push; // gathered word to the buffer
	logic [31:0] push_data;
	logic full; // buffer cannot take a word
	// next-value logic for the sequencer
	always_comb begin
		logic [1:0] code;
		logic [3:0] mask;
		logic [2:0] nb;
		logic [2:0] sum;
		logic [31:0] cur;
		logic go;
		code = ack_code(size_s, a_s);
		mask = lane_mask(size_s, a_s);
		nb = ack_bytes(code);
		sum = cnt_r + nb;
		cur = (cnt_r == 3'h0) ? tx_data : rdw_r;
		// wait states while no item to read or no room for one
		go = rw_s ? (cnt_r != 3'h0 || tx_valid) : !full;
		state_nxt = state_r;
		ack_nxt = ack_r;
		ack_oe_nxt = ack_oe_r;
		dout_nxt = dout_r;
		doe_nxt = doe_r;
		cnt_nxt = cnt_r;
		asm_nxt = asm_r;
		rdw_nxt = rdw_r;
		tx_ready_nxt = 1'b0;
		push = 1'b0;
		push_data = asm_r;
		case (state_r)
			IDLE: begin
				// both acks high by pull-up meanwhile: a wait state
				if (sel && go) begin
					state_nxt = ACK;
					ack_nxt = code;
					ack_oe_nxt = 1'b1;
					cnt_nxt = (sum >= ITEM_BYTES) ? 3'h0 : sum;
					if (rw_s) begin
						dout_nxt = place(cur, nb);
						doe_nxt = mask;
						rdw_nxt = shift_out(cur, nb);
						tx_ready_nxt = (sum >= ITEM_BYTES);
					end else begin
						asm_nxt = merge(asm_r, extract(d_s, mask), nb);
						push = (sum >= ITEM_BYTES);
						push_data = asm_nxt;
					end
				end
			end
			ACK: begin
				// hold answer until the strobes go away
				if (!sel) begin
					state_nxt = REL;
					ack_nxt = ACK_WAIT; // drive high briefly to speed rise
					doe_nxt = 4'h0;
				end
			end
			REL: begin
				state_nxt = IDLE;
				ack_oe_nxt = 1'b0;
			end
			default: begin
				state_nxt = IDLE;
				ack_nxt = ACK_WAIT;
				ack_oe_nxt = 1'b0;
				doe_nxt = 4'h0;
			end
		endcase
	end
	// registers of the sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= IDLE;
			ack_r <= ACK_WAIT;
			ack_oe_r <= 1'b0;
			dout_r <= 32'h00000000;
			doe_r <= 4'h0;
			cnt_r <= 3'h0;
			asm_r <= 32'h00000000;
			rdw_r <= 32'h00000000;
			tx_ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ack_r <= ack_nxt;
			ack_oe_r <= ack_oe_nxt;
			dout_r <= dout_nxt;
			doe_r <= doe_nxt;
			cnt_r <= cnt_nxt;
			asm_r <= asm_nxt;
			rdw_r <= rdw_nxt;
			tx_ready_r <= tx_ready_nxt;
		end
	end
	assign bus.xfer_ack_second_n = ack_r[1];
	assign bus.xfer_ack_first_n = ack_r[0];
	assign bus.ack_oe = ack_oe_r;
	assign bus.dev_data = dout_r;
	assign bus.dev_data_oe = doe_r;
	assign tx_ready = tx_ready_r;
	// ==================================================
	// two-entry receive buffer; full stalls the host by wait states
	logic [31:0] e0_r, e0_nxt; // head, shown to the user
	logic [31:0] e1_r, e1_nxt;
	logic [1:0] fill_r, fill_nxt;
	logic valid_r, valid_nxt;
	// next-value logic for the buffer
	always_comb begin
		logic pop;
		pop = valid_r && rx_ready;
		e0_nxt = e0_r;
		e1_nxt = e1_r;
		fill_nxt = fill_r;
		case ({push, pop})
			2'b10: begin
				if (fill_r == 2'h0) e0_nxt = push_data;
				else e1_nxt = push_data;
				fill_nxt = fill_r + 2'h1;
			end
			2'b01: begin
				e0_nxt = e1_r;
				fill_nxt = fill_r - 2'h1;
			end
			2'b11: begin
				// one leaves, one arrives: level unchanged
				if (fill_r == 2'h1) e0_nxt = push_data;
				else begin
					e0_nxt = e1_r;
					e1_nxt = push_data;
				end
			end
			default: begin
				fill_nxt = fill_r;
			end
		endcase
		valid_nxt = (fill_nxt != 2'h0);
	end
	// registers of the buffer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			e0_r <= 32'h00000000;
			e1_r <= 32'h00000000;
			fill_r <= 2'h0;
			valid_r <= 1'b0;
		end else begin
			e0_r <= e0_nxt;
			e1_r <= e1_nxt;
			fill_r <= fill_nxt;
			valid_r <= valid_nxt;
		end
	end
	assign full = (fill_r == 2'h2);
	assign rx_valid = valid_r;
	assign rx_data = e0_r;
endmodule : coproc_port_dev
`default_nettype wire

// File: coproc_port_host.sv
/*
 * host end of the port: moves one 32-bit item per command as one or
 * more bus cycles, sized by the acknowledge pair it gets back.
 * assumes the device answers each cycle and releases after strobes.
 */
`timescale 1ns/100ps
`default_nettype none
module coproc_port_host
	import coproc_port_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	coproc_bus_if.host_mp bus,
	input wire logic cmd_valid,
	output logic cmd_ready, // level, idle and able to take a command
	input wire logic cmd_write,
	input wire logic cmd_size_sel,
	input wire logic [4:0] cmd_addr,
	input wire logic [31:0] cmd_data,
	output logic resp_valid, // one-cycle pulse per finished read item
	output logic [31:0] resp_data
);
	typedef enum logic [1:0] {H_IDLE, H_WAIT, H_NEG} host_state_type;
	// ==================================================
	// pin synchronisers for acks and data
	logic [33:0] pin_m_r; // first stage, read only by second
	logic [33:0] pin_s_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_m_r <= {2'h3, 32'h0};
			pin_s_r <= {2'h3, 32'h0};
		end else begin
			pin_m_r <= {bus.ack_second_bus_n, bus.ack_first_bus_n,
				bus.data_bus};
			pin_s_r <= pin_m_r;
		end
	end
	// ==================================================
	// cycle sequencer
	host_state_type st_r, st_nxt;
	logic strb_r, strb_nxt; // high while strobes asserted
	logic wr_r, wr_nxt;
	logic size_r, size_nxt;
	logic [4:0] addr_r, addr_nxt;
	logic [31:0] word_r, word_nxt; // write word left to send
	logic [31:0] acc_r, acc_nxt; // read gathering
	logic [2:0] cnt_r, cnt_nxt;
	logic oe_r, oe_nxt;
	logic rdy_r, rdy_nxt;
	logic rv_r, rv_nxt;
	// next-value logic
	always_comb begin
		logic [1:0] ack;
		logic [2:0] nb;
		logic [2:0] sum;
		ack = pin_s_r[33:32];
		nb = ack_bytes(ack);
		sum = cnt_r + nb;
		st_nxt = st_r;
		strb_nxt = strb_r;
		wr_nxt = wr_r;
		size_nxt = size_r;
		addr_nxt = addr_r;
		word_nxt = word_r;
		acc_nxt = acc_r;
		cnt_nxt = cnt_r;
		oe_nxt = oe_r;
		rdy_nxt = rdy_r;
		rv_nxt = 1'b0;
		case (st_r)
			H_IDLE: begin
				if (cmd_valid && rdy_r) begin
					st_nxt = H_WAIT;
					rdy_nxt = 1'b0;
					wr_nxt = cmd_write;
					size_nxt = cmd_size_sel;
					addr_nxt = cmd_addr;
					word_nxt = cmd_data;
					cnt_nxt = 3'h0;
					strb_nxt = 1'b1;
					oe_nxt = cmd_write;
				end
			end
			H_WAIT: begin
				// both acks high means wait states
				if (ack != ACK_WAIT) begin
					st_nxt = H_NEG;
					strb_nxt = 1'b0;
					cnt_nxt = sum;
					acc_nxt = merge(acc_r, extract(pin_s_r[31:0],
						lane_mask(size_r, addr_r)), nb);
					word_nxt = shift_out(word_r, nb);
				end
			end
			H_NEG: begin
				// next cycle only after acks are seen high again
				if (ack == ACK_WAIT) begin
					if (cnt_r >= ITEM_BYTES) begin
						st_nxt = H_IDLE;
						oe_nxt = 1'b0;
						rdy_nxt = 1'b1;
						rv_nxt = !wr_r;
					end else begin
						st_nxt = H_WAIT;
						strb_nxt = 1'b1;
					end
				end
			end
			default: begin
				st_nxt = H_IDLE;
				strb_nxt = 1'b0;
				oe_nxt = 1'b0;
				rdy_nxt = 1'b1;
			end
		endcase
	end
	// registers of the sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_r <= H_IDLE;
			strb_r <= 1'b0;
			wr_r <= 1'b0;
			size_r <= 1'b1;
			addr_r <= 5'h00;
			word_r <= 32'h00000000;
			acc_r <= 32'h00000000;
			cnt_r <= 3'h0;
			oe_r <= 1'b0;
			rdy_r <= 1'b1;
			rv_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			strb_r <= strb_nxt;
			wr_r <= wr_nxt;
			size_r <= size_nxt;
			addr_r <= addr_nxt;
			word_r <= word_nxt;
			acc_r <= acc_nxt;
			cnt_r <= cnt_nxt;
			oe_r <= oe_nxt;
			rdy_r <= rdy_nxt;
			rv_r <= rv_nxt;
		end
	end
	// same-numbered bits on both sides, top piece replicated on lanes;
	// the device picks the lanes, so a lower-half or low-byte cycle still
	// finds the current piece where it looks
	assign bus.host_data = place(word_r,
		ack_bytes(ack_code(size_r, addr_r)));
	assign bus.host_data_oe = oe_r;
	assign bus.addr = addr_r;
	assign bus.size_sel = size_r;
	assign bus.rw = !wr_r;
	assign bus.cs_n = !strb_r;
	assign bus.addr_strobe_n = !strb_r;
	assign bus.data_strobe_n = !strb_r;
	assign cmd_ready = rdy_r;
	assign resp_valid = rv_r;
	assign resp_data = acc_r;
endmodule : coproc_port_host
`default_nettype wire

// File: coproc_port_pkg.sv
/*
 * shared constants, lane and acknowledge helpers for the coprocessor port.
 * assumes both ends run on one clock and import this package whole.
 */
`default_nettype none
package coproc_port_pkg;
	// ==================================================
	// address bit positions
	localparam int BUS_WIDTH_BIT = 0;
	localparam int WORD_SELECT_BIT = 1;
	localparam int UPPER_HALF_SELECT_BIT = 4;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	// ==================================================
	// acknowledge pair {second, first}, active low
	localparam logic [1:0] ACK_32 = 2'h0;
	localparam logic [1:0] ACK_16 = 2'h1;
	localparam logic [1:0] ACK_8 = 2'h2;
	localparam logic [1:0] ACK_WAIT = 2'h3;
	// lane masks, bit 3 is the top byte lane
	localparam logic [3:0] LANES_ALL = 4'hF;
	localparam logic [3:0] LANES_UPPER = 4'hC;
	localparam logic [3:0] LANES_LOWER = 4'h3;
	localparam logic [3:0] LANE_TOP = 4'h8;
	localparam logic [2:0] ITEM_BYTES = 3'h4;
	// ==================================================
	// port width and acknowledge code from select pin and address
	function automatic logic [1:0] ack_code(input logic size_sel,
			input logic [ADDR_W-1:0] a);
		if (!size_sel) ack_code = ACK_8;
		else if (a[BUS_WIDTH_BIT] && a[UPPER_HALF_SELECT_BIT])
			ack_code = ACK_32;
		else ack_code = ACK_16;
	endfunction : ack_code
	// active lanes for one bus cycle
	function automatic logic [3:0] lane_mask(input logic size_sel,
			input logic [ADDR_W-1:0] a);
		if (size_sel && a[BUS_WIDTH_BIT])
			lane_mask = a[UPPER_HALF_SELECT_BIT] ? LANES_ALL : LANES_UPPER;
		else if (size_sel)
			lane_mask = (a[UPPER_HALF_SELECT_BIT] && a[WORD_SELECT_BIT]) ?
				LANES_LOWER : LANES_UPPER;
		else lane_mask = LANE_TOP >> a[WORD_SELECT_BIT:BUS_WIDTH_BIT];
	endfunction : lane_mask
	// bytes moved per cycle for an acknowledge code
	function automatic logic [2:0] ack_bytes(input logic [1:0] ack);
		case (ack)
			ACK_32: ack_bytes = 3'h4;
			ACK_16: ack_bytes = 3'h2;
			default: ack_bytes = 3'h1;
		endcase
	endfunction : ack_bytes
	// right-aligned piece taken from the active lanes
	function automatic logic [31:0] extract(input logic [31:0] b,
			input logic [3:0] m);
		case (m)
			LANES_ALL: extract = b;
			LANES_UPPER: extract = {16'h0000, b[31:16]};
			LANES_LOWER: extract = {16'h0000, b[15:0]};
			4'h8: extract = {24'h000000, b[31:24]};
			4'h4: extract = {24'h000000, b[23:16]};
			4'h2: extract = {24'h000000, b[15:8]};
			4'h1: extract = {24'h000000, b[7:0]};
			default: extract = 32'h00000000;
		endcase
	endfunction : extract
	// top part of a word copied onto every lane; enables pick lanes
	function automatic logic [31:0] place(input logic [31:0] w,
			input logic [2:0] nb);
		case (nb)
			3'h4: place = w;
			3'h2: place = {2{w[31:16]}};
			default: place = {4{w[31:24]}};
		endcase
	endfunction : place
	// append a piece below what was gathered, most significant first
	function automatic logic [31:0] merge(input logic [31:0] acc,
			input logic [31:0] p, input logic [2:0] nb);
		case (nb)
			3'h4: merge = p;
			3'h2: merge = {acc[15:0], p[15:0]};
			default: merge = {acc[23:0], p[7:0]};
		endcase
	endfunction : merge
	// drop the part already sent
	function automatic logic [31:0] shift_out(input logic [31:0] w,
			input logic [2:0] nb);
		case (nb)
			3'h4: shift_out = 32'h00000000;
			3'h2: shift_out = {w[15:0], 16'h0000};
			default: shift_out = {w[23:0], 8'h00};
		endcase
	endfunction : shift_out
endpackage : coproc_port_pkg
`default_nettype wire

// File: coproc_port_sva.sv
/*
 * checker for the pins between host and coprocessor port ends.
 * assumes it is instantiated beside the interface, one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module coproc_port_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic [4:0] addr,
	input wire logic size_sel,
	input wire logic rw,
	input wire logic cs_n,
	input wire logic addr_strobe_n,
	input wire logic data_strobe_n,
	input wire logic [3:0] dev_data_oe,
	input wire logic ack_oe,
	input wire logic ack_first_bus_n,
	input wire logic ack_second_bus_n
);
	// ==================================================
	// expected codes, worked out apart from the package helpers
	wire logic [1:0] pair; // {second, first} as seen on the wire
	wire logic [1:0] exp_code; // width from select pin and address bits 0 and 4
	wire logic [3:0] exp_mask; // active byte lanes, bit 3 on top
	assign pair = {ack_second_bus_n, ack_first_bus_n};
	assign exp_code = !size_sel ? 2'h2 : (addr[0] && addr[4]) ? 2'h0 : 2'h1;
	assign exp_mask = (size_sel && addr[0]) ? (addr[4] ? 4'hF : 4'hC) :
		size_sel ? ((addr[4] && addr[1]) ? 4'h3 : 4'hC) : 4'h8 >> addr[1:0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ==================================================
	// named steps of one bus cycle
	sequence seq_start;
		$fell(addr_strobe_n);
	endsequence
	sequence seq_wait2; // no answer before the sync delay has passed
		(pair == 2'h3) [*2];
	endsequence
	sequence seq_answer; // a real answer stands on the wire
		ack_oe && pair != 2'h3;
	endsequence
	a_ack_code: assert property (seq_answer |->
		pair == exp_code) else $error("ack pair does not match port width");
	a_read_lanes: assert property (seq_answer and rw |->
		dev_data_oe == exp_mask) else $error("read lanes wrong");
	a_write_quiet: assert property (!rw |->
		dev_data_oe == 4'h0) else $error("device drives data in a write");
	a_ack_latency: assert property (seq_start |-> seq_wait2)
		else $error("answer came too early");
	a_ack_holds: assert property (seq_answer and !addr_strobe_n |=>
		$stable(pair)) else $error("ack changed while strobes low");
	a_ack_release: assert property ($rose(addr_strobe_n) |->
		##[1:6] !ack_oe) else $error("acks not released");
	a_idle_quiet: assert property (cs_n [*6] |->
		!ack_oe && dev_data_oe == 4'h0) else $error("drive while idle");
	a_ack_only_sel: assert property ($fell(ack_first_bus_n) ||
		$fell(ack_second_bus_n) |-> !cs_n && !addr_strobe_n)
		else $error("answer without select");
	a_strobes_together: assert property (cs_n == addr_strobe_n &&
		data_strobe_n == addr_strobe_n) else $error("strobes split");
endmodule : coproc_port_sva
`default_nettype wire

// File: tb_coproc_bus_port_sizing.sv
/*
 * testbench: host end and coprocessor end joined by the interface.
 * assumes one 100 MHz clock; inputs change on the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_coproc_bus_port_sizing;
	import coproc_port_pkg::*;
	// ==================================================
	// stimulus and bookkeeping
	logic clk, reset, rx_valid, rx_ready, tx_valid, tx_ready;
	logic cmd_valid, cmd_ready, cmd_write, cmd_size_sel, resp_valid;
	logic [31:0] rx_data, tx_data, cmd_data, resp_data;
	logic [4:0] cmd_addr;
	logic [1:0] prv = 2'h3; // ack pair one edge ago, idle level at start
	logic hold; // keeps the receiver stalled
	logic [31:0] rxq[$], rsq[$]; // expected items, oldest first
	logic [7:0] pcq[$]; // expected top byte of each write piece
	integer seed = 32'hc162c27e;
	int bad_count = 0, cmp_count = 0;
	coproc_bus_if bus_if ();
	coproc_port_dev u_coproc_port_dev (.clk(clk), .reset(reset),
		.bus(bus_if), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready));
	coproc_port_host u_coproc_port_host (.clk(clk), .reset(reset),
		.bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_write(cmd_write), .cmd_size_sel(cmd_size_sel),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.resp_valid(resp_valid), .resp_data(resp_data));
	coproc_port_sva u_coproc_port_sva (.clk(clk), .reset(reset),
		.addr(bus_if.addr), .size_sel(bus_if.size_sel), .rw(bus_if.rw),
		.cs_n(bus_if.cs_n), .addr_strobe_n(bus_if.addr_strobe_n),
		.data_strobe_n(bus_if.data_strobe_n),
		.dev_data_oe(bus_if.dev_data_oe), .ack_oe(bus_if.ack_oe),
		.ack_first_bus_n(bus_if.ack_first_bus_n),
		.ack_second_bus_n(bus_if.ack_second_bus_n));
	// ==================================================
	// clock, compare and closing
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	// oldest expected write piece, unknown when none is noted
	function automatic logic [7:0] pc_next();
		pc_next = pcq.size() ? pcq.pop_front() : 8'hXX;
	endfunction : pc_next
	// one item per command; writes note the item and its pieces
	task automatic do_item(input logic w, input logic sz,
			input logic [4:0] a, input logic [31:0] d);
		int n;
		int nb;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		// a host that never comes back to idle counts as a mismatch
		chk({31'h0, cmd_ready}, 32'h1);
		{cmd_write, cmd_size_sel, cmd_addr, cmd_data} = {w, sz, a, d};
		cmd_valid = 1'b1;
		nb = !sz ? 1 : (a[0] && a[4]) ? 4 : 2;
		if (w) begin
			rxq.push_back(d);
			for (int k = 0; k < 4 / nb; k++) pcq.push_back(d[31-8*nb*k -: 8]);
		end else rsq.push_back(d);
		@(negedge clk);
		cmd_valid = 1'b0;
		if (!w) begin
			// a late item stalls the read with wait states
			repeat ($random(seed) & 7) @(negedge clk);
			{tx_valid, tx_data} = {1'b1, d};
			n = 0;
			while (tx_ready !== 1'b1 && n < 500) begin
				@(negedge clk);
				n++;
			end
			// item fully read, then the pulse must be gone a cycle later
			chk({31'h0, tx_ready}, 32'h1);
			tx_valid = 1'b0;
			@(negedge clk);
			chk({31'h0, tx_ready}, 32'h0);
		end
	endtask : do_item
	// ==================================================
	// watchers: user sides and the wire itself
	always @(posedge clk) begin
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			chk(rx_data, rxq.size() ? rxq.pop_front() : 32'hX);
		if (resp_valid === 1'b1)
			chk(resp_data, rsq.size() ? rsq.pop_front() : 32'hX);
		// first edge of each write answer: top byte must be the next piece
		if (prv == 2'h3 && bus_if.rw === 1'b0 &&
				{bus_if.ack_second_bus_n, bus_if.ack_first_bus_n} != 2'h3)
			chk(bus_if.data_bus[31:24], pc_next());
		prv <= {bus_if.ack_second_bus_n, bus_if.ack_first_bus_n};
	end
	// receiver takes words at random unless held
	always @(negedge clk) rx_ready <= !hold && $random(seed) % 2 != 0;
	// watchdog, well beyond the expected run length
	initial begin
		#300000;
		bad_count++;
		end_sim();
	end
	// ==================================================
	// main sequence
	initial begin
		{cmd_valid, cmd_write, cmd_size_sel, cmd_addr, cmd_data} = '0;
		{tx_valid, tx_data} = '0;
		hold = 1'b1;
		reset = 1'b1;
		repeat (16) @(negedge clk);
		reset = 1'b0;
		// fill the two-entry buffer; the third item must stall
		for (int i = 0; i < 3; i++) do_item(1'b1, 1'b1, 5'h11, $random(seed));
		repeat (30) @(negedge clk);
		chk({31'h0, cmd_ready}, 32'h0);
		chk({31'h0, rx_valid}, 32'h1);
		hold = 1'b0;
		// every width, address and direction, random data
		for (int i = 0; i < 128; i++)
			do_item(i[6], i[5], i[4:0], $random(seed));
		repeat (100) @(negedge clk);
		chk(rxq.size() + rsq.size() + pcq.size(), 32'h0);
		end_sim();
	end
endmodule : tb_coproc_bus_port_sizing
`default_nettype wire
